//--- ilso_params.svh
// constants and rule overview for the inrush limit select and oring block
// Overview of operation
// RULE1: boost forces full-scale code during inrush
// RULE2: inrush ends when current drops below limit
// RULE3: programmed limit holds while channel stays enabled
// RULE4: all-ones code always gives maximum limit
// RULE5: boost clear: programmed code applies, 0111 sixty
// RULE6: code 0101 gives fifty percent after inrush
// RULE7: code in reg0[3:0], boost reg6[4]
// RULE8: gate high above upper oring threshold
// RULE9: gate low below lower threshold, else hold
// RULE10: oring enable clear turns gate drive off
// RULE11: full-scale code applies full fast-trip, pass off
// RULE12: inrush flag set on enable rise, cleared
`ifndef ILSO_PARAMS_SVH
`define ILSO_PARAMS_SVH
`define ILSO_CODE_W 4
`define ILSO_CODE_FULL 4'hf
`define ILSO_CODE_SIXTY 4'h7
`define ILSO_CODE_FIFTY 4'h5
`define ILSO_CODE_LSB 0
`define ILSO_CODE_MSB 3
`define ILSO_BOOST_BIT 4
`define ILSO_REG_W 8
`define ILSO_SYNC_W 5
`define ILSO_SYNC_EN 4
`define ILSO_SYNC_BELOW 3
`define ILSO_SYNC_TRIP 2
`define ILSO_SYNC_HI 1
`define ILSO_SYNC_LO 0
`define ILSO_FLAG_RST 1'b0
`define ILSO_THR_RST 8'h00
`endif

//--- ilso_pkg.sv
// types for the inrush limit select and oring block
package ilso_pkg;
    typedef struct packed {
        logic [3:0] limit_code;
        logic [3:0] trip_code;
    } ilso_thr_t;
    typedef enum logic [1:0] {
        ILSO_OFF = 2'b00,
        ILSO_INRUSH = 2'b01,
        ILSO_RUN = 2'b10
    } ilso_state_t;
endpackage : ilso_pkg

//--- ilso_oring.sv
// oring hysteresis controller for the blocking gate
`timescale 1ns/1ps
module ilso_oring (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised comparator flags, and the enable, a register bit taken unsynced
    input wire logic diff_above_hi,
    input wire logic diff_below_lo,
    input wire logic oring_enable,
    // gate drive
    output logic blocking_gate_drive
);
    logic gate_ff;
    logic nxt_gate;

    // above upper sets, below lower clears, between holds
    assign nxt_gate = !oring_enable ? 1'b0 :                    // RULE10
                      diff_above_hi ? 1'b1 :                    // RULE8
                      diff_below_lo ? 1'b0 : gate_ff;           // RULE9

    // gate state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gate_ff <= 1'b0;
        else gate_ff <= nxt_gate;
    end

    assign blocking_gate_drive = gate_ff;
endmodule : ilso_oring

//--- ilso_top.sv
// threshold code select and oring gate control for one 12 v channel
`timescale 1ns/1ps
`include "ilso_params.svh"
module ilso_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration register images
    input wire logic [7:0] limit_code_register,
    input wire logic [7:0] boost_config_register,
    input wire logic oring_enable,
    // channel control and analog comparator flags (asynchronous)
    input wire logic channel_enable,
    input wire logic below_limit,
    input wire logic over_fast_trip,
    input wire logic diff_above_hi,
    input wire logic diff_below_lo,
    // outputs
    output ilso_pkg::ilso_thr_t thr_out,
    output logic inrush_active,
    output logic pass_gate_drive,
    output logic blocking_gate_drive
);
    import ilso_pkg::*;

    // raw pin-domain flags, one bit each, positions from the header
    wire [`ILSO_SYNC_W-1:0] flag_raw;
    // the same flags after both synchroniser stages
    wire [`ILSO_SYNC_W-1:0] flag_s;

    // enable history for the rising-edge detector
    logic en_d_ff;
    logic nxt_en_d;

    // inrush phase tracking
    ilso_state_t state_ff;
    ilso_state_t nxt_state;

    // threshold codes for the regulation loop and the fast-trip compare
    // travel together as one struct
    ilso_thr_t thr_ff;
    ilso_thr_t nxt_thr;

    // pass gate drive
    logic pass_ff;
    logic nxt_pass;

    // inrush indication
    logic inr_ff;
    logic nxt_inr;

    // current-limit field of a register image; kept in one place so a
    // moved field changes one line
    function automatic logic [`ILSO_CODE_W-1:0] code_field(
        input logic [`ILSO_REG_W-1:0] img
    );
        code_field = img[`ILSO_CODE_MSB:`ILSO_CODE_LSB];
    endfunction : code_field

    // code for one threshold: full scale only in a boosted inrush;
    // an all-ones code is full scale anyway, so the boost is moot there
    function automatic logic [`ILSO_CODE_W-1:0] pick_code(
        input logic [`ILSO_CODE_W-1:0] prog,
        input logic boost_on,
        input logic inrush_on
    );
        if (boost_on && inrush_on) begin
            pick_code = `ILSO_CODE_FULL; // RULE1
        end else begin
            pick_code = prog; // RULE5 RULE6 RULE4
        end
    endfunction : pick_code

    // gather the asynchronous flags; only the synchroniser reads these
    assign flag_raw[`ILSO_SYNC_EN] = channel_enable;
    assign flag_raw[`ILSO_SYNC_BELOW] = below_limit;
    assign flag_raw[`ILSO_SYNC_TRIP] = over_fast_trip;
    assign flag_raw[`ILSO_SYNC_HI] = diff_above_hi;
    assign flag_raw[`ILSO_SYNC_LO] = diff_below_lo;

    // two flops per flag; flags are synced one by one, so two pins that
    // move together may land a clock apart, which every path here takes
    genvar gi;
    generate
        for (gi = 0; gi < `ILSO_SYNC_W; gi = gi + 1) begin : g_sync
            logic meta_ff;
            logic sync_ff;
            // stage one is read by stage two and nothing else
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_ff <= `ILSO_FLAG_RST;
                    sync_ff <= `ILSO_FLAG_RST;
                end else begin
                    meta_ff <= flag_raw[gi];
                    sync_ff <= meta_ff;
                end
            end
            assign flag_s[gi] = sync_ff;
        end
    endgenerate

    // synced flags under their own names; everything below reads only
    // these, never the raw pins
    wire en_s = flag_s[`ILSO_SYNC_EN];
    wire below_s = flag_s[`ILSO_SYNC_BELOW];
    wire trip_s = flag_s[`ILSO_SYNC_TRIP];
    wire hi_s = flag_s[`ILSO_SYNC_HI];
    wire lo_s = flag_s[`ILSO_SYNC_LO];

    // enable edge detect; history resets low, the idle level of the pin,
    // so no false edge follows reset
    wire en_rise = en_s && !en_d_ff;
    assign nxt_en_d = en_s;

    // register field decode; the images are on this clock, so no sync
    wire [`ILSO_CODE_W-1:0] prog_code =
        code_field(limit_code_register); // RULE7
    wire boost = boost_config_register[`ILSO_BOOST_BIT]; // RULE7

    // phase decode shared by both threshold codes
    wire in_inrush = (state_ff == ILSO_INRUSH);

    // inrush phase tracking; every fresh enable starts a new inrush
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ILSO_OFF: begin
                if (en_rise) nxt_state = ILSO_INRUSH; // RULE12
            end
            ILSO_INRUSH: begin
                if (!en_s) nxt_state = ILSO_OFF; // RULE12
                else if (below_s) nxt_state = ILSO_RUN; // RULE2
            end
            // below_limit is not looked at here: no way back to full scale
            ILSO_RUN: begin
                if (!en_s) nxt_state = ILSO_OFF; // RULE3
            end
            // the fourth code is never entered; recover to off
            default: begin
                nxt_state = ILSO_OFF;
            end
        endcase
    end

    // both thresholds follow one code; limit and trip never split
    always_comb begin
        nxt_thr.limit_code = pick_code(prog_code, boost, in_inrush); // RULE2
        nxt_thr.trip_code = pick_code(prog_code, boost, in_inrush); // RULE11
    end

    // pass gate on while enabled, off at once on a fast trip; the slow
    // turn-on after a trip belongs to the analog loop, not to this logic
    assign nxt_pass = en_s && !trip_s; // RULE11

    // inrush flag carries the state that this edge will load
    assign nxt_inr = (nxt_state == ILSO_INRUSH); // RULE12

    // enable history register; one clock behind the synced enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_d_ff <= `ILSO_FLAG_RST;
        end else begin
            en_d_ff <= nxt_en_d;
        end
    end

    // inrush phase register; off through reset, and only a synced
    // enable rise leaves off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ILSO_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // threshold code register; codes move one edge after the state,
    // so the analog side never sees a code ahead of its phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thr_ff <= `ILSO_THR_RST;
        end else begin
            thr_ff <= nxt_thr;
        end
    end

    // pass gate drive register; low through reset so the channel
    // stays off until the synced enable arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pass_ff <= `ILSO_FLAG_RST;
        end else begin
            pass_ff <= nxt_pass;
        end
    end

    // inrush indication register; loaded with the state, so the two
    // never disagree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inr_ff <= `ILSO_FLAG_RST;
        end else begin
            inr_ff <= nxt_inr;
        end
    end

    // oring hysteresis on the synced flags; its enable is a register
    // bit on this clock and goes in unsynced
    ilso_oring u_oring (
        .clk(clk),
        .rst(rst),
        .diff_above_hi(hi_s),
        .diff_below_lo(lo_s),
        .oring_enable(oring_enable),
        .blocking_gate_drive(blocking_gate_drive)
    );

    // outputs straight from their flops
    assign thr_out = thr_ff;
    assign inrush_active = inr_ff;
    assign pass_gate_drive = pass_ff;
endmodule : ilso_top

//--- ilso_checker_assertions.sv
// port checks for the inrush select and oring block
`timescale 1ns/1ps
module ilso_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stimulus
    input wire logic [7:0] limit_code_register,
    input wire logic [7:0] boost_config_register,
    input wire logic oring_enable,
    input wire logic channel_enable,
    input wire logic over_fast_trip,
    input wire logic diff_above_hi,
    input wire logic diff_below_lo,
    // responses
    input wire ilso_pkg::ilso_thr_t thr_out,
    input wire logic inrush_active,
    input wire logic pass_gate_drive,
    input wire logic blocking_gate_drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // comparator flags held past the sync delay
    sequence fwd_s; (oring_enable && diff_above_hi)[*4]; endsequence
    sequence rev_s;
        (oring_enable && diff_below_lo && !diff_above_hi)[*4];
    endsequence
    boost_full_a: assert property (inrush_active && boost_config_register[4]
        |=> thr_out == 8'hff) else $error("boost code wrong");
    code_after_a: assert property ($fell(inrush_active)
        |=> thr_out == {2{limit_code_register[3:0]}}) else $error("code");
    stay_low_a: assert property (channel_enable[*4] ##0 !inrush_active
        ##1 channel_enable |-> !inrush_active) else $error("re-entered");
    all_ones_a: assert property (limit_code_register[3:0] == 4'hf
        |=> thr_out == 8'hff) else $error("all ones not max");
    inrush_on_a: assert property ($rose(channel_enable)
        |-> ##[2:4] inrush_active) else $error("no inrush");
    gate_up_a: assert property (fwd_s |-> blocking_gate_drive)
        else $error("gate not high");
    gate_down_a: assert property (rev_s |-> !blocking_gate_drive)
        else $error("gate not low");
    oring_off_a: assert property (!oring_enable |=> !blocking_gate_drive)
        else $error("gate on while disabled");
    trip_off_a: assert property (over_fast_trip[*4] |-> !pass_gate_drive)
        else $error("pass on after trip");
endmodule : ilso_checker
bind ilso_top ilso_checker chk (.*);

//--- ilso_fet_model.sv
// far-side power stage: rail differential and sense flags
`timescale 1ns/1ps
module ilso_fet_model (
    // supply situation set by the bench
    input wire logic supply_fwd,
    input wire logic supply_rev,
    input wire logic load_short,
    // comparator flags back to the channel
    output logic diff_above_hi,
    output logic diff_below_lo,
    output logic over_fast_trip
);
    // a back-fed rail masks any forward drop
    assign diff_above_hi = supply_fwd && !supply_rev;
    assign diff_below_lo = supply_rev;
    assign over_fast_trip = load_short;
endmodule : ilso_fet_model

//--- inrush_limit_select_and_oring_tb_top.sv
// self-checking bench for the inrush select and oring block
`timescale 1ns/1ps
module inrush_limit_select_and_oring_tb_top;
    logic clk = 0, rst = 1, oe = 0, en = 0, bl = 0, fw = 0, rv = 0, sh = 0;
    logic [7:0] code = 8'h00, boost = 8'h00;
    logic hi, lo, trip, inr, pass, blk;
    ilso_pkg::ilso_thr_t thr;
    int mismatches = 0, total_checks = 0, cycles = 0;
    ilso_fet_model fet (.supply_fwd(fw), .supply_rev(rv), .load_short(sh),
        .diff_above_hi(hi), .diff_below_lo(lo), .over_fast_trip(trip));
    ilso_top dut (.clk(clk), .rst(rst), .limit_code_register(code),
        .boost_config_register(boost), .oring_enable(oe),
        .channel_enable(en), .below_limit(bl), .over_fast_trip(trip),
        .diff_above_hi(hi), .diff_below_lo(lo), .thr_out(thr),
        .inrush_active(inr), .pass_gate_drive(pass),
        .blocking_gate_drive(blk));
    always #25 clk = ~clk;
    // hang guard, far beyond the whole sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    task cyc(input int n); repeat (n) @(negedge clk); endtask : cyc
    task ck(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : ck
    task wrap_up;
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task t_boost(input logic [3:0] c, input logic b, input logic [7:0] e);
        code = {4'h0, c}; boost = {3'h0, b, 4'h0}; en = 1; cyc(6);
        ck(inr === 1'b1 && thr === e, "inrush code");
        bl = 1; cyc(6); bl = 0; cyc(5);
        ck(inr === 1'b0 && thr === {c, c}, "run code");
        code = 8'h05; cyc(3);
        ck(thr === 8'h55, "half code");
        en = 0; cyc(6);
        ck(inr === 1'b0, "inrush left on");
    endtask : t_boost
    task t_oring;
        oe = 1; fw = 1; cyc(5); ck(blk === 1'b1, "gate low");
        fw = 0; cyc(5); ck(blk === 1'b1, "no hold");
        rv = 1; cyc(5); ck(blk === 1'b0, "gate high");
        rv = 0; fw = 1; cyc(5); oe = 0; cyc(2);
        ck(blk === 1'b0, "gate on when off");
    endtask : t_oring
    task t_trip;
        code = 8'h0f; en = 1; cyc(6); ck(pass === 1'b1, "pass off");
        ck(inr === 1'b1, "inrush ended early");
        sh = 1; cyc(5); ck(pass === 1'b0, "pass on");
        sh = 0; en = 0; cyc(6);
        ck(inr === 1'b0, "inrush kept after disable");
    endtask : t_trip
    initial begin
        cyc(16); rst = 0; cyc(2);
        t_boost(4'h7, 1'b1, 8'hff);
        t_boost(4'h7, 1'b0, 8'h77);
        t_boost(4'hf, 1'b1, 8'hff);
        t_oring();
        t_trip();
        wrap_up();
    end
endmodule : inrush_limit_select_and_oring_tb_top
